/* File: hdl/eod_decoder.sv */
// decoder and executor of the eight extended core instructions
//
// Behaviour
// - add 6-bit literal to chosen pointer in one cycle; select 3 adds then returns.
// - subtract 6-bit literal from chosen pointer in one cycle, flags untouched.
// - subtract with select 3 hits pointer 2 then returns, two cycles total.
// - word 0x0014 calls through the working register in two cycles, flags untouched.
// - indexed-to-absolute move, two words, bit 7 clear, three cycles.
// - indexed-to-indexed move, two words, bit 7 set, three cycles.
// - push literal stores at pointer 2 address then decrements pointer 2.
// - extended words decode only when the extended set enable is high.
`timescale 1ns/10ps
module eod_decoder
	import eod_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic extended_set_enable,
	// instruction fetch
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	output logic instr_ready,
	output logic legacy_valid,
	// core state
	input wire logic [EOD_DATA_W-1:0] working_register,
	input wire logic [EOD_PCHI_W-1:0] pc_high,
	// program flow requests
	output logic ret_req,
	output logic call_req,
	output logic [EOD_PCHI_W+EOD_DATA_W-1:0] call_target,
	// data memory
	output logic mem_rd_en,
	output logic [EOD_PTR_W-1:0] mem_rd_addr,
	input wire logic [EOD_DATA_W-1:0] mem_rd_data,
	output logic mem_wr_en,
	output logic [EOD_PTR_W-1:0] mem_wr_addr,
	output logic [EOD_DATA_W-1:0] mem_wr_data,
	// pointer view
	output logic [EOD_NUM_PTR-1:0][EOD_PTR_W-1:0] file_pointer
);
	eod_ptr_if pif ();

	eod_ptr_file u_ptr (
		.clk(clk),
		.rst(rst),
		.pif(pif)
	);

	eod_state_e state_r, state_nxt;
	logic ret_req_r, ret_req_nxt;
	logic call_req_r, call_req_nxt;
	logic [EOD_PCHI_W+EOD_DATA_W-1:0] tgt_r, tgt_nxt;
	logic rd_en_r, rd_en_nxt;
	logic [EOD_PTR_W-1:0] rd_addr_r, rd_addr_nxt;
	logic wr_en_r, wr_en_nxt;
	logic [EOD_PTR_W-1:0] wr_addr_r, wr_addr_nxt;
	logic [EOD_DATA_W-1:0] wr_data_r, wr_data_nxt;
	logic [EOD_DATA_W-1:0] src_data_r, src_data_nxt;
	logic take;
	logic is_ext_grp, is_add, is_sub, is_push, is_move, is_call, is_ext;
	logic [EOD_PTR_W-1:0] ptr2;

	assign ptr2 = pif.ptr[2];
	// only idle or waiting for the move's second word accepts a word
	assign instr_ready = (state_r == EOD_S_IDLE) || (state_r == EOD_S_MW2);
	assign take = instr_valid && instr_ready;

	always_comb begin
		// disabled set leaves every word to the standard decoder
		is_ext_grp = extended_set_enable && (instr_word[15:12] == EOD_EXT_PREFIX);
		is_add = is_ext_grp && (instr_word[11:8] == EOD_OP_ADD);
		is_sub = is_ext_grp && (instr_word[11:8] == EOD_OP_SUB);
		is_push = is_ext_grp && (instr_word[11:8] == EOD_OP_PUSH);
		is_move = is_ext_grp && (instr_word[11:8] == EOD_OP_MOVE);
		is_call = extended_set_enable && (instr_word == EOD_CALL_WR_WORD);
		is_ext = is_add || is_sub || is_push || is_move || is_call;
	end

	assign legacy_valid = take && (state_r == EOD_S_IDLE) && !is_ext;

	always_comb begin
		state_nxt = state_r;
		ret_req_nxt = 1'b0;
		call_req_nxt = 1'b0;
		tgt_nxt = tgt_r;
		rd_en_nxt = 1'b0;
		rd_addr_nxt = rd_addr_r;
		wr_en_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		src_data_nxt = src_data_r;
		pif.op = EOD_P_NONE;
		pif.sel = instr_word[EOD_SEL_POS+:2];
		pif.lit = instr_word[EOD_LIT6_POS+:6];
		unique case (state_r)
			EOD_S_IDLE: begin
				if (take && is_add) begin
					pif.op = EOD_P_ADD;
					if (pif.sel == EOD_SEL_PTR2_RET) begin
						ret_req_nxt = 1'b1;
						state_nxt = EOD_S_RET;
					end
				end else if (take && is_sub) begin
					pif.op = EOD_P_SUB;
					if (pif.sel == EOD_SEL_PTR2_RET) begin
						ret_req_nxt = 1'b1;
						state_nxt = EOD_S_RET;
					end
				end else if (take && is_push) begin
					// write address is taken before the decrement lands
					pif.op = EOD_P_DEC2;
					wr_en_nxt = 1'b1;
					wr_addr_nxt = ptr2;
					wr_data_nxt = instr_word[7:0];
				end else if (take && is_call) begin
					call_req_nxt = 1'b1;
					tgt_nxt = {pc_high, working_register};
					state_nxt = EOD_S_CALL;
				end else if (take && is_move) begin
					rd_en_nxt = 1'b1;
					rd_addr_nxt = ptr2 + {5'h00, instr_word[6:0]};
					// destination kind kept in the write address bit 0 slot
					wr_addr_nxt = {11'h000, instr_word[EOD_MOVE_KIND_BIT]};
					state_nxt = EOD_S_MRD;
				end
			end
			EOD_S_RET: begin
				state_nxt = EOD_S_IDLE;
			end
			EOD_S_CALL: begin
				state_nxt = EOD_S_IDLE;
			end
			EOD_S_MRD: begin
				// read data must stand by the end of the strobe cycle
				src_data_nxt = mem_rd_data;
				state_nxt = EOD_S_MW2;
			end
			EOD_S_MW2: begin
				if (take) begin
					wr_en_nxt = 1'b1;
					wr_data_nxt = src_data_r;
					if (wr_addr_r[0]) begin
						wr_addr_nxt = ptr2 + {5'h00, instr_word[6:0]};
					end else begin
						wr_addr_nxt = instr_word[11:0];
					end
					state_nxt = EOD_S_IDLE;
				end
			end
			default: begin
				state_nxt = EOD_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= EOD_S_IDLE;
			ret_req_r <= 1'b0;
			call_req_r <= 1'b0;
			tgt_r <= '0;
			rd_en_r <= 1'b0;
			rd_addr_r <= '0;
			wr_en_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			src_data_r <= '0;
		end else begin
			state_r <= state_nxt;
			ret_req_r <= ret_req_nxt;
			call_req_r <= call_req_nxt;
			tgt_r <= tgt_nxt;
			rd_en_r <= rd_en_nxt;
			rd_addr_r <= rd_addr_nxt;
			wr_en_r <= wr_en_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_data_r <= wr_data_nxt;
			src_data_r <= src_data_nxt;
		end
	end

	assign ret_req = ret_req_r;
	assign call_req = call_req_r;
	assign call_target = tgt_r;
	assign mem_rd_en = rd_en_r;
	assign mem_rd_addr = rd_addr_r;
	assign mem_wr_en = wr_en_r;
	// second-word address is only meaningful while the strobe is high
	assign mem_wr_addr = wr_addr_r;
	assign mem_wr_data = wr_data_r;
	assign file_pointer = pif.ptr;

	logic [15:0] w0;
	assign w0 = instr_word;

	a_add_updates: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_add && w0[7:6] != 2'h3
		|=> file_pointer[$past(w0[7:6])] ==
		$past(file_pointer[w0[7:6]]) + {6'h00, $past(w0[5:0])})
		else $error("add literal did not update pointer");
	a_add_return: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_add && w0[7:6] == 2'h3
		|=> ret_req && !instr_ready ##1 instr_ready && !ret_req)
		else $error("add with return took wrong cycles");
	a_sub_updates: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_sub && w0[7:6] != 2'h3
		|=> file_pointer[$past(w0[7:6])] ==
		$past(file_pointer[w0[7:6]]) - {6'h00, $past(w0[5:0])} && !ret_req)
		else $error("sub literal did not update pointer");
	a_sub_return: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_sub && w0[7:6] == 2'h3
		|=> ret_req && file_pointer[2] == $past(file_pointer[2]) - {6'h00, $past(w0[5:0])})
		else $error("sub with return wrong");
	a_call_target: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_call
		|=> call_req && call_target == {$past(pc_high), $past(working_register)}
		##1 !call_req && instr_ready)
		else $error("call through working register wrong");
	a_push_store: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_push
		|=> mem_wr_en && mem_wr_addr == $past(file_pointer[2])
		&& mem_wr_data == $past(w0[7:0])
		&& file_pointer[2] == $past(file_pointer[2]) - 12'h001)
		else $error("push literal wrong");
	a_move_read: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && is_move
		|=> mem_rd_en && mem_rd_addr == $past(file_pointer[2]) + {5'h00, $past(w0[6:0])})
		else $error("move source address wrong");
	a_move_abs: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_MW2 && !wr_addr_r[0]
		|=> mem_wr_en && mem_wr_addr == $past(w0[11:0]) && mem_wr_data == $past(src_data_r))
		else $error("absolute move write wrong");
	a_move_idx: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_MW2 && wr_addr_r[0]
		|=> mem_wr_en && mem_wr_addr == $past(file_pointer[2]) + {5'h00, $past(w0[6:0])})
		else $error("indexed move write wrong");
	a_gate_off: assert property (@(posedge clk) disable iff (rst)
		take && state_r == EOD_S_IDLE && !extended_set_enable |-> legacy_valid
		##1 !ret_req && !call_req && !mem_wr_en && !mem_rd_en)
		else $error("extended word decoded while disabled");

	c_add_ret: cover property (@(posedge clk) disable iff (rst) ret_req);
	c_call: cover property (@(posedge clk) disable iff (rst) call_req);
	c_move: cover property (@(posedge clk) disable iff (rst) state_r == EOD_S_MW2 && take);
	c_push: cover property (@(posedge clk) disable iff (rst)
		mem_wr_en && state_r == EOD_S_IDLE);
endmodule

/* File: hdl/eod_pkg.sv */
// constants and types shared by the extended instruction decoder
package eod_pkg;
	localparam int EOD_PTR_W = 12;
	localparam int EOD_DATA_W = 8;
	localparam int EOD_PCHI_W = 13;
	localparam int EOD_NUM_PTR = 3;
	localparam logic [3:0] EOD_EXT_PREFIX = 4'he;
	localparam logic [3:0] EOD_OP_ADD = 4'h8;
	localparam logic [3:0] EOD_OP_SUB = 4'h9;
	localparam logic [3:0] EOD_OP_PUSH = 4'ha;
	localparam logic [3:0] EOD_OP_MOVE = 4'hb;
	localparam logic [3:0] EOD_SECOND_PREFIX = 4'hf;
	localparam logic [15:0] EOD_CALL_WR_WORD = 16'h0014;
	localparam logic [1:0] EOD_SEL_PTR2_RET = 2'h3;
	localparam int EOD_LIT6_POS = 0;
	localparam int EOD_SEL_POS = 6;
	localparam int EOD_MOVE_KIND_BIT = 7;
	localparam logic [EOD_PTR_W-1:0] EOD_PTR_RESET = 12'h000;
	localparam int EOD_RET_CYCLES = 2;
	typedef enum logic [4:0] {
		EOD_S_IDLE = 5'b00001,
		EOD_S_RET = 5'b00010,
		EOD_S_CALL = 5'b00100,
		EOD_S_MRD = 5'b01000,
		EOD_S_MW2 = 5'b10000
	} eod_state_e;
	typedef enum logic [1:0] {
		EOD_P_NONE = 2'h0,
		EOD_P_ADD = 2'h1,
		EOD_P_SUB = 2'h2,
		EOD_P_DEC2 = 2'h3
	} eod_pop_e;
endpackage

/* File: hdl/eod_ptr_if.sv */
// link between the decoder control and its pointer file
`timescale 1ns/10ps
interface eod_ptr_if;
	import eod_pkg::*;
	eod_pop_e op;
	logic [1:0] sel;
	logic [5:0] lit;
	logic [EOD_NUM_PTR-1:0][EOD_PTR_W-1:0] ptr;
	modport ctl (output op, output sel, output lit, input ptr);
	modport regs (input op, input sel, input lit, output ptr);
endinterface

/* File: hdl/eod_ptr_file.sv */
// the three file pointers and their literal arithmetic
`timescale 1ns/10ps
module eod_ptr_file
	import eod_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control side
	eod_ptr_if.regs pif
);
	logic [EOD_NUM_PTR-1:0][EOD_PTR_W-1:0] ptr_r;
	logic [EOD_NUM_PTR-1:0][EOD_PTR_W-1:0] ptr_nxt;
	logic [1:0] idx;

	always_comb begin
		ptr_nxt = ptr_r;
		// select 3 means pointer 2 with return
		idx = (pif.sel == EOD_SEL_PTR2_RET) ? 2'h2 : pif.sel;
		unique case (pif.op)
			EOD_P_ADD: ptr_nxt[idx] = ptr_r[idx] + {6'h00, pif.lit};
			EOD_P_SUB: ptr_nxt[idx] = ptr_r[idx] - {6'h00, pif.lit};
			EOD_P_DEC2: ptr_nxt[2] = ptr_r[2] - 12'h001;
			EOD_P_NONE: ;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_r <= {EOD_NUM_PTR{EOD_PTR_RESET}};
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	assign pif.ptr = ptr_r;
endmodule

/* File: tb/extended_op_decoder_tb.sv */
// self-checking bench for the extended instruction decoder
`timescale 1ns/10ps
module extended_op_decoder_tb;
	import eod_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic extended_set_enable = 1'b1;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic instr_ready, legacy_valid, ret_req, call_req, mem_rd_en, mem_wr_en;
	logic [EOD_DATA_W-1:0] working_register = 8'h00;
	logic [EOD_PCHI_W-1:0] pc_high = 13'h0000;
	logic [EOD_PCHI_W+EOD_DATA_W-1:0] call_target;
	logic [EOD_PTR_W-1:0] mem_rd_addr, mem_wr_addr;
	logic [EOD_DATA_W-1:0] mem_rd_data = 8'h00;
	logic [EOD_DATA_W-1:0] mem_wr_data;
	logic [EOD_NUM_PTR-1:0][EOD_PTR_W-1:0] file_pointer;
	logic [EOD_PTR_W-1:0] ptr [3] = '{12'h000, 12'h000, 12'h000};
	logic lv;
	int failures = 0;
	int check_count = 0;
	eod_decoder eod_decoder_inst (.clk(clk), .rst(rst), .extended_set_enable(extended_set_enable),
		.instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
		.legacy_valid(legacy_valid), .working_register(working_register), .pc_high(pc_high),
		.ret_req(ret_req), .call_req(call_req), .call_target(call_target),
		.mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
		.mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.file_pointer(file_pointer));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// offer a word, hold it until taken, return just after the taking edge
	task automatic send(input logic [15:0] w);
		logic r;
		int i;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		for (i = 0; i < 8; i++) begin
			#1;
			r = instr_ready;
			lv = legacy_valid;
			@(posedge clk);
			if (r === 1'b1) break;
		end
		if (i == 8) check("word taken", 32'h0, 32'h1);
		instr_valid <= 1'b0;
		#1;
	endtask
	task automatic t_add_sub();
		for (int f = 0; f < 3; f++) begin
			send({8'he8, f[1:0], 6'h2a + 6'(f)});
			ptr[f] = ptr[f] + {6'h00, 6'h2a + 6'(f)};
			check("pointer after add", file_pointer[f], ptr[f]);
			check("no return on add", ret_req, 1'b0);
			send({8'he9, f[1:0], 6'h31});
			ptr[f] = ptr[f] - 12'h031;
			check("pointer after sub", file_pointer[f], ptr[f]);
		end
		send(16'he8c5);
		ptr[2] = ptr[2] + 12'h005;
		check("pointer2 add return", file_pointer[2], ptr[2]);
		check("return after add", ret_req, 1'b1);
		check("busy in return", instr_ready, 1'b0);
		send(16'he9ff);
		ptr[2] = ptr[2] - 12'h03f;
		check("pointer2 sub return", file_pointer[2], ptr[2]);
		check("return after sub", ret_req, 1'b1);
		check("busy in sub return", instr_ready, 1'b0);
		check("pointer0 untouched", file_pointer[0], ptr[0]);
		@(posedge clk);
		#1;
		check("return is one pulse", ret_req, 1'b0);
		check("ready after return", instr_ready, 1'b1);
		$display("add and sub test done");
	endtask
	task automatic t_push();
		logic [EOD_PTR_W-1:0] p;
		p = ptr[2];
		send(16'heaa5);
		ptr[2] = p - 12'h001;
		check("push not legacy", lv, 1'b0);
		check("push strobe", mem_wr_en, 1'b1);
		check("push address", mem_wr_addr, p);
		check("push data", mem_wr_data, 8'ha5);
		check("push decrement", file_pointer[2], ptr[2]);
		$display("push test done");
	endtask
	task automatic t_call();
		@(posedge clk);
		working_register <= 8'h9c;
		pc_high <= 13'h1abc;
		send(EOD_CALL_WR_WORD);
		check("call request", call_req, 1'b1);
		check("call target", call_target, {13'h1abc, 8'h9c});
		check("busy in call", instr_ready, 1'b0);
		check("pointer2 kept", file_pointer[2], ptr[2]);
		@(posedge clk);
		#1;
		check("call one pulse", call_req, 1'b0);
		check("ready after call", instr_ready, 1'b1);
		$display("call test done");
	endtask
	task automatic t_move(input logic kind, input logic [6:0] off, input logic [15:0] w2,
		input logic [7:0] d);
		logic [EOD_PTR_W-1:0] dst;
		@(posedge clk);
		mem_rd_data <= d;
		dst = kind ? ptr[2] + {5'h00, w2[6:0]} : w2[11:0];
		send({8'heb, kind, off});
		check("move read strobe", mem_rd_en, 1'b1);
		check("move source", mem_rd_addr, 12'(ptr[2] + {5'h00, off}));
		check("busy in move read", instr_ready, 1'b0);
		send(w2);
		check("move write strobe", mem_wr_en, 1'b1);
		check("move destination", mem_wr_addr, dst);
		check("move data", mem_wr_data, d);
		$display("move test done");
	endtask
	task automatic t_disabled();
		@(posedge clk);
		extended_set_enable <= 1'b0;
		send(16'hea3c);
		check("legacy when disabled", lv, 1'b1);
		check("no push when disabled", mem_wr_en, 1'b0);
		send(16'he805);
		check("no add when disabled", file_pointer[0], ptr[0]);
		check("pointer2 when disabled", file_pointer[2], ptr[2]);
		@(posedge clk);
		extended_set_enable <= 1'b1;
		$display("disabled set test done");
	endtask
	// about 50 cycles of work; a hang is cut off well beyond that
	initial begin
		#(25 * 3000);
		failures++;
		results();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("pointers at reset", file_pointer, '0);
		check("ready at reset", instr_ready, 1'b1);
		check("target at reset", call_target, 21'h000000);
		t_add_sub();
		t_push();
		t_call();
		t_move(1'b0, 7'h7f, 16'hf123, 8'h5a);
		t_move(1'b1, 7'h10, 16'hfa85, 8'hc3);
		t_disabled();
		t_push();
		results();
	end
endmodule
